// ==== hw/sfc_frontend.sv ====
// Command front end of a serial multi-lane flash
//
// Summary of operation
// - All fields shift most significant bit first
// - Input bits captured on rising serial clock
// - One opcode byte, then address or data
// - Reads may stop anywhere; then deselect
// - Write-type commands need whole byte count
// - Partial program byte: nothing, latch kept
// - Decode 06H, 04H, 50H without further bytes
// - 05H/35H stream status low/high byte
// - 01H takes one or two, 31H upper
// - 11H writes config; 45H/15H read it
// - 03H: three address bytes, no dummy
// - 0BH/3BH/6BH: address plus dummy byte
// - BBH, EBH, E7H: address then dummy
// - Dual output: odd bits lane 1
// - Quad I/O: four dummy clocks, upper nibble
// - Word read: two dummy clocks only
// - Security registers at 00H, 04H/08H/0CH
// - Wrap: seventh quad clock carries bits
// - ABH plus three dummies: wake, stream identifier
// - 5AH: address, dummy, stream parameter bytes
// - Ignore writes into protected array range
`timescale 1ns/1ps
module sfc_frontend
    import sfc_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                sclk_pin,
    input  wire logic                select_n_pin,
    input  wire logic [3:0]          lane_in_pin,
    output sfc_pkg::sfc_lanes_s      lanes,
    input  wire logic [7:0]          rd_data,
    input  wire logic                range_protected,
    output logic                     rd_req,
    output logic [23:0]              rd_addr,
    output logic                     sec_hit,
    output logic [1:0]               sec_index,
    output logic                     write_latch_flag,
    output logic                     deep_power_down,
    output logic [7:0]               wrap_setting_byte,
    output logic                     exec_pulse,
    output logic [7:0]               exec_opcode,
    output logic [15:0]              status_q_out,
    output logic [7:0]               config_out
);
    import sfc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    logic [5:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            // Idle pin levels (clock low, select high) so no false edge follows reset
            s1_q <= 6'h1F;
            s2_q <= 6'h1F;
            s3_q <= 6'h1F;
        end else begin
            s1_q <= {sclk_pin, select_n_pin, lane_in_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic sel, rise, fall, desel;
    logic [3:0] din;
    assign sel   = ~s2_q[4];
    assign rise  = s2_q[5] & ~s3_q[5] & sel;
    assign fall  = ~s2_q[5] & s3_q[5] & sel;
    assign desel = s2_q[4] & ~s3_q[4];
    assign din   = s2_q[3:0];

    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == SFC_OP_READ) || (op == SFC_OP_FREAD) || (op == SFC_OP_DOREAD)
               || (op == SFC_OP_QOREAD) || (op == SFC_OP_DIOREAD)
               || (op == SFC_OP_QIOREAD) || (op == SFC_OP_QWREAD) || (op == SFC_OP_SFDP);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command state
    sfc_state_e st_q, st_d;
    logic [7:0]  op_q, op_d, sh_q, sh_d, ob_q, ob_d;
    logic [23:0] ad_q, ad_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [2:0]  bit_q, bit_d;
    logic [2:0]  width_q, width_d;
    logic [15:0] clks_q, clks_d;
    logic [1:0]  nb_q, nb_d;
    logic        wel_q, wel_d, vwe_q, vwe_d, dpd_q, dpd_d, oe_q, oe_d, rq_q, rq_d;
    logic [15:0] stat_q, stat_d;
    logic [15:0] wdat_q, wdat_d;
    logic [7:0]  cfg_q, cfg_d, wrap_q, wrap_d, xop_q, xop_d;
    logic        xp_q, xp_d;

    always_comb begin
        logic [7:0] nsh;
        logic [7:0] srcb;
        nsh = sh_q;
        st_d = st_q; op_d = op_q; sh_d = sh_q; ob_d = ob_q; ad_d = ad_q;
        cnt_d = cnt_q; bit_d = bit_q; width_d = width_q; clks_d = clks_q;
        nb_d = nb_q; wel_d = wel_q; vwe_d = vwe_q; dpd_d = dpd_q; oe_d = oe_q;
        rq_d = 1'b0; stat_d = stat_q; wdat_d = wdat_q; cfg_d = cfg_q;
        wrap_d = wrap_q; xop_d = xop_q; xp_d = 1'b0;
        srcb = rd_data;
        if (op_q == SFC_OP_RDSR1) srcb = stat_q[7:0];
        else if (op_q == SFC_OP_RDSR2) srcb = stat_q[15:8];
        else if (op_q == SFC_OP_RDCR_A || op_q == SFC_OP_RDCR_B) srcb = cfg_q;
        else if (op_q == SFC_OP_RDID) srcb = SFC_DEV_ID;
        if (rise) begin
            clks_d = clks_q + 16'h0001;
            case (width_q)
                3'h4: nsh = {sh_q[3:0], din};
                3'h2: nsh = {sh_q[5:0], din[1:0]};
                default: nsh = {sh_q[6:0], din[0]};
            endcase
            sh_d = nsh;
        end
        case (st_q)
            SFC_IDLE: begin
                oe_d = 1'b0;
                if (sel) begin
                    st_d = SFC_OPC; bit_d = 3'h0; width_d = 3'h1; clks_d = 16'h0000;
                end
            end
            SFC_OPC: if (rise) begin
                bit_d = bit_q + 3'h1;
                if (bit_q == SFC_BIT_LAST) begin
                    op_d = nsh; cnt_d = 6'h00; bit_d = 3'h0; nb_d = 2'h0; st_d = SFC_IDLE;
                    if (dpd_q && nsh != SFC_OP_RDID) st_d = SFC_DUMMY;      // asleep: nothing executes, but read opcodes still stream after their dummy clocks
                    else if (is_read(nsh) || nsh == SFC_OP_PP || nsh == SFC_OP_SE) begin
                        st_d = SFC_ADDR;
                        if (nsh == SFC_OP_DIOREAD) width_d = 3'h2;
                        else if (nsh == SFC_OP_QIOREAD || nsh == SFC_OP_QWREAD)
                            width_d = 3'h4;
                    end else if (nsh == SFC_OP_RDSR1 || nsh == SFC_OP_RDSR2
                              || nsh == SFC_OP_RDCR_A || nsh == SFC_OP_RDCR_B) begin
                        st_d = SFC_DOUT; ob_d = 8'h00;
                    end else if (nsh == SFC_OP_RDID) begin
                        st_d = SFC_DUMMY; dpd_d = 1'b0;
                    end else if (nsh == SFC_OP_WRAP) begin
                        st_d = SFC_DUMMY; width_d = 3'h4;
                    end else if (nsh == SFC_OP_WRSR || nsh == SFC_OP_WRSR2
                              || nsh == SFC_OP_WRCR) begin
                        st_d = SFC_DIN;
                    end else if (nsh == SFC_OP_WRITE_ENABLE_CMD || nsh == SFC_OP_WRDI
                              || nsh == SFC_OP_VWREN || nsh == SFC_OP_DPD) begin
                        st_d = SFC_DIN;
                    end else st_d = SFC_DUMMY;
                end
            end
            SFC_ADDR: if (rise) begin
                cnt_d = cnt_q + {3'h0, width_q};
                ad_d = (width_q == 3'h4) ? {ad_q[19:0], din}
                     : (width_q == 3'h2) ? {ad_q[21:0], din[1:0]} : {ad_q[22:0], din[0]};
                if (cnt_q + {3'h0, width_q} == SFC_ADDR_BITS) begin
                    cnt_d = 6'h00;
                    if (op_q == SFC_OP_PP || op_q == SFC_OP_SE) begin
                        st_d = SFC_DIN; bit_d = 3'h0;
                    end else if (op_q == SFC_OP_READ) begin
                        st_d = SFC_DOUT; rq_d = 1'b1;
                    end else st_d = SFC_DUMMY;
                end
            end
            SFC_DUMMY: if (rise) begin
                cnt_d = cnt_q + 6'h01;
                if (op_q == SFC_OP_WRAP && cnt_q == SFC_WRAP_CLK)
                    wrap_d = {1'b0, din[2:0], 4'h0};
                if (is_read(op_q) || op_q == SFC_OP_RDID) begin
                    if ((op_q == SFC_OP_QIOREAD && cnt_q == SFC_DUMMY_QIO - 6'h01)
                     || (op_q == SFC_OP_QWREAD && cnt_q == SFC_DUMMY_QW - 6'h01)
                     || (op_q == SFC_OP_DIOREAD && cnt_q == SFC_DUMMY_DIO - 6'h01)
                     || (op_q == SFC_OP_RDID && cnt_q == SFC_DUMMY_RDID - 6'h01)
                     || (op_q != SFC_OP_RDID && cnt_q == SFC_DUMMY_1B - 6'h01)) begin
                        st_d = SFC_DOUT; rq_d = (op_q != SFC_OP_RDID);
                        width_d = (op_q == SFC_OP_DOREAD || op_q == SFC_OP_DIOREAD) ? 3'h2
                                : (op_q == SFC_OP_QOREAD || op_q == SFC_OP_QIOREAD
                                   || op_q == SFC_OP_QWREAD) ? 3'h4 : 3'h1;
                    end
                end
            end
            SFC_DIN: if (rise) begin
                bit_d = bit_q + 3'h1;
                if (bit_q == SFC_BIT_LAST) begin
                    if (nb_q != 2'h3) nb_d = nb_q + 2'h1;
                    wdat_d = (nb_q == 2'h0) ? {wdat_q[15:8], nsh} : {nsh, wdat_q[7:0]};
                end
            end
            SFC_DOUT: begin
                if (fall) begin
                    oe_d = 1'b1;
                    if (bit_q == 3'h0) ob_d = srcb;
                    else ob_d = (width_q == 3'h4) ? {ob_q[3:0], 4'h0}
                              : (width_q == 3'h2) ? {ob_q[5:0], 2'h0} : {ob_q[6:0], 1'b0};
                    bit_d = bit_q + width_q;
                    if (bit_q + width_q == 3'h0 && is_read(op_q)) begin
                        ad_d = ad_q + 24'h000001; rq_d = 1'b1;
                    end
                end
                if (bit_q == 3'h0 && fall) ob_d = srcb;
            end
            default: st_d = SFC_IDLE;
        endcase
        if (desel) begin
            st_d = SFC_IDLE; oe_d = 1'b0; width_d = 3'h1;
            if (clks_q[2:0] == 3'h0 && st_q == SFC_DIN && clks_q != 16'h0000) begin
                xp_d = 1'b1; xop_d = op_q;
                if (op_q == SFC_OP_WRITE_ENABLE_CMD) wel_d = 1'b1;
                else if (op_q == SFC_OP_WRDI) wel_d = 1'b0;
                else if (op_q == SFC_OP_VWREN) vwe_d = 1'b1;
                else if (op_q == SFC_OP_DPD) dpd_d = 1'b1;
                else if (op_q == SFC_OP_SE || op_q == SFC_OP_PP) begin
                    // A protected target is ignored and keeps the latch
                    if (wel_q && !range_protected && (op_q == SFC_OP_SE || nb_q != 2'h0))
                        wel_d = 1'b0;
                end else if ((wel_q || vwe_q) && nb_q != 2'h0) begin
                    if (op_q == SFC_OP_WRSR) begin
                        stat_d[7:0] = wdat_q[7:0];
                        if (nb_q == 2'h2) stat_d[15:8] = wdat_q[15:8];
                    end else if (op_q == SFC_OP_WRSR2) stat_d[15:8] = wdat_q[7:0];
                    else if (op_q == SFC_OP_WRCR) cfg_d = wdat_q[7:0];
                    wel_d = 1'b0;
                    vwe_d = 1'b0;
                end
            end
            // A partial program byte leaves the write latch alone
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_q    <= SFC_IDLE;
            op_q    <= 8'h00;
            sh_q    <= 8'h00;
            ob_q    <= 8'h00;
            ad_q    <= 24'h000000;
            cnt_q   <= 6'h00;
            bit_q   <= 3'h0;
            width_q <= 3'h1;
            clks_q  <= 16'h0000;
            nb_q    <= 2'h0;
            wel_q   <= 1'b0;
            vwe_q   <= 1'b0;
            dpd_q   <= 1'b0;
            oe_q    <= 1'b0;
            rq_q    <= 1'b0;
            stat_q  <= 16'h0000;
            wdat_q  <= 16'h0000;
            cfg_q   <= 8'h00;
            wrap_q  <= 8'h00;
            xop_q   <= 8'h00;
            xp_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            op_q    <= op_d;
            sh_q    <= sh_d;
            ob_q    <= ob_d;
            ad_q    <= ad_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            width_q <= width_d;
            clks_q  <= clks_d;
            nb_q    <= nb_d;
            wel_q   <= wel_d;
            vwe_q   <= vwe_d;
            dpd_q   <= dpd_d;
            oe_q    <= oe_d;
            rq_q    <= rq_d;
            stat_q  <= stat_d;
            wdat_q  <= wdat_d;
            cfg_q   <= cfg_d;
            wrap_q  <= wrap_d;
            xop_q   <= xop_d;
            xp_q    <= xp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: lane mapping follows the bus width of the data phase
    always_comb begin
        lanes.o  = 4'h0;
        lanes.oe = 4'h0;
        if (oe_q && sel) begin
            if (width_q == 3'h4) begin
                lanes.o = ob_q[7:4]; lanes.oe = 4'hF;
            end else if (width_q == 3'h2) begin
                lanes.o = {2'h0, ob_q[7:6]}; lanes.oe = 4'h3;
            end else begin
                lanes.o = {2'h0, ob_q[7], 1'b0}; lanes.oe = 4'h2;
            end
        end
    end
    assign rd_req            = rq_q;
    assign rd_addr           = ad_q;
    assign sec_hit           = (ad_q[23:16] == SFC_SEC_HI) && (ad_q[15:8] == SFC_SEC_1
                             || ad_q[15:8] == SFC_SEC_2 || ad_q[15:8] == SFC_SEC_3);
    assign sec_index         = ad_q[11:10];
    assign write_latch_flag  = wel_q;
    assign deep_power_down   = dpd_q;
    assign wrap_setting_byte = wrap_q;
    assign exec_pulse        = xp_q;
    assign exec_opcode       = xop_q;
    assign status_q_out      = stat_q;
    assign config_out        = cfg_q;
endmodule // sfc_frontend

// ==== hw/sfc_pkg.sv ====
// Package for the serial flash command front end
package sfc_pkg;
    localparam logic [7:0] SFC_OP_WRITE_ENABLE_CMD   = 8'h06;
    localparam logic [7:0] SFC_OP_WRDI   = 8'h04;
    localparam logic [7:0] SFC_OP_VWREN  = 8'h50;
    localparam logic [7:0] SFC_OP_RDSR1  = 8'h05;
    localparam logic [7:0] SFC_OP_RDSR2  = 8'h35;
    localparam logic [7:0] SFC_OP_WRSR   = 8'h01;
    localparam logic [7:0] SFC_OP_WRSR2  = 8'h31;
    localparam logic [7:0] SFC_OP_WRCR   = 8'h11;
    localparam logic [7:0] SFC_OP_RDCR_A = 8'h45;
    localparam logic [7:0] SFC_OP_RDCR_B = 8'h15;
    localparam logic [7:0] SFC_OP_READ   = 8'h03;
    localparam logic [7:0] SFC_OP_FREAD  = 8'h0B;
    localparam logic [7:0] SFC_OP_DOREAD = 8'h3B;
    localparam logic [7:0] SFC_OP_QOREAD = 8'h6B;
    localparam logic [7:0] SFC_OP_DIOREAD = 8'hBB;
    localparam logic [7:0] SFC_OP_QIOREAD = 8'hEB;
    localparam logic [7:0] SFC_OP_QWREAD = 8'hE7;
    localparam logic [7:0] SFC_OP_WRAP   = 8'h77;
    localparam logic [7:0] SFC_OP_RDID   = 8'hAB;
    localparam logic [7:0] SFC_OP_SFDP   = 8'h5A;
    localparam logic [7:0] SFC_OP_PP     = 8'h02;
    localparam logic [7:0] SFC_OP_SE     = 8'h20;
    localparam logic [7:0] SFC_OP_DPD    = 8'hB9;
    localparam logic [7:0] SFC_SEC_HI    = 8'h00;
    localparam logic [7:0] SFC_SEC_1     = 8'h04;
    localparam logic [7:0] SFC_SEC_2     = 8'h08;
    localparam logic [7:0] SFC_SEC_3     = 8'h0C;
    localparam logic [7:0] SFC_DEV_ID    = 8'h5C; // Arbitrary value
    localparam logic [2:0] SFC_BIT_LAST  = 3'h7;
    localparam logic [5:0] SFC_ADDR_BITS = 6'h18;
    localparam logic [5:0] SFC_DUMMY_1B  = 6'h08;
    localparam logic [5:0] SFC_DUMMY_RDID = 6'h18;
    localparam logic [5:0] SFC_DUMMY_QIO = 6'h04;
    localparam logic [5:0] SFC_DUMMY_QW  = 6'h02;
    localparam logic [5:0] SFC_DUMMY_DIO = 6'h04;
    localparam logic [5:0] SFC_WRAP_CLK  = 6'h06;
    localparam logic [5:0] SFC_WRAP_CLKS = 6'h08;

    typedef enum logic [5:0] {
        SFC_IDLE  = 6'b000001,
        SFC_OPC   = 6'b000010,
        SFC_ADDR  = 6'b000100,
        SFC_DUMMY = 6'b001000,
        SFC_DIN   = 6'b010000,
        SFC_DOUT  = 6'b100000
    } sfc_state_e;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } sfc_lanes_s;

    typedef struct packed {
        logic       wr_status;
        logic [1:0] nbytes;
        logic [15:0] status;
        logic [7:0] config_reg;
    } sfc_wr_s;
endpackage

// ==== sim/sfc_host_model.sv ====
// Host controller model driving the flash front end pins
`timescale 1ns/1ps
module sfc_host_model
    import sfc_pkg::*;
(
    input  wire logic                clock,
    output logic                     sclk_pin,
    output logic                     select_n_pin,
    output logic [3:0]               lane_in_pin,
    input  wire sfc_pkg::sfc_lanes_s lanes
);
    logic [3:0] host_v = 4'h0;
    logic [3:0] host_en = 4'h0;
    initial sclk_pin = 1'b0;
    initial select_n_pin = 1'b1;
    ////////////////////////////////////////
    // Released lanes show the inverse of the last value, so stale data cannot pass
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_in_pin[i] = lanes.oe[i] ? lanes.o[i] : (host_en[i] ? host_v[i] : ~host_v[i]);
        end
    end
    ////////////////////////////////////////
    // Clock idles low outside frames; data moves only in the low phase
    task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] seen);
        if (en != 4'h0) host_v = v;
        host_en = en;
        repeat (5) @(posedge clock);
        #1;
        seen = lane_in_pin;
        sclk_pin = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        sclk_pin = 1'b0;
    endtask
    task automatic open_frame();
        select_n_pin = 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic close_frame();
        repeat (2) @(posedge clock);
        #1;
        select_n_pin = 1'b1;
        host_en = 4'h0;
        repeat (8) @(posedge clock);
        #1;
    endtask
endmodule // sfc_host_model

// ==== sim/sfc_frontend_monitor.sv ====
// Port level checks of the flash command front end
`timescale 1ns/1ps
module sfc_frontend_monitor
    import sfc_pkg::*;
(
    input wire logic                clock,
    input wire logic                reset,
    input wire logic                sclk_pin,
    input wire logic                select_n_pin,
    input wire sfc_pkg::sfc_lanes_s lanes,
    input wire logic                rd_req,
    input wire logic [23:0]         rd_addr,
    input wire logic                sec_hit,
    input wire logic [1:0]          sec_index,
    input wire logic                write_latch_flag,
    input wire logic                exec_pulse,
    input wire logic [7:0]          exec_opcode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    property p_float;
        select_n_pin [*6] |-> lanes.oe == 4'h0;
    endproperty
    a_float: assert property (p_float) else $error("lanes driven while deselected");
    property p_stable;
        !select_n_pin && $rose(sclk_pin) |-> ##1 $stable(lanes.o) [*4];
    endproperty
    a_stable: assert property (p_stable) else $error("lane data moved near rise");
    property p_exec;
        exec_pulse |-> select_n_pin && $past(select_n_pin, 2);
    endproperty
    a_exec: assert property (p_exec) else $error("execute while selected");
    property p_wel_set;
        exec_pulse && exec_opcode == SFC_OP_WRITE_ENABLE_CMD |-> ##[0:2] write_latch_flag;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("write enable lost");
    property p_wel_clr;
        exec_pulse && exec_opcode == SFC_OP_WRDI |-> ##[0:2] !write_latch_flag;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("write disable lost");
    property p_wel_frame;
        $changed(write_latch_flag) |-> select_n_pin;
    endproperty
    a_wel_frame: assert property (p_wel_frame) else $error("latch moved in frame");
    property p_rdreq;
        rd_req |-> !$past(select_n_pin, 4);
    endproperty
    a_rdreq: assert property (p_rdreq) else $error("array request outside frame");
    property p_sec;
        sec_hit |-> rd_addr[23:16] == SFC_SEC_HI && rd_addr[15:8] == {4'h0, sec_index, 2'b00};
    endproperty
    a_sec: assert property (p_sec) else $error("security decode wrong");
endmodule // sfc_frontend_monitor

// ==== sim/sfc_frontend_bench.sv ====
// Self-checking bench of the flash command front end
`timescale 1ns/1ps
module sfc_frontend_bench;
    import sfc_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        sclk_pin, select_n_pin, rd_req, sec_hit, write_latch_flag, deep_power_down;
    logic        exec_pulse, range_protected = 1'b0;
    logic [3:0]  lane_in_pin;
    logic [1:0]  sec_index;
    logic [7:0]  rd_data = 8'h96, wrap_setting_byte, exec_opcode, config_out;
    logic [15:0] status_q_out;
    logic [23:0] rd_addr;
    sfc_lanes_s  lanes;
    int          failures = 0, n_checks = 0, n_exec = 0;
    always #5 clock = ~clock;
    always @(posedge clock) if (exec_pulse === 1'b1) n_exec <= n_exec + 1;
    sfc_frontend i_dut (.clock(clock), .reset(reset), .sclk_pin(sclk_pin),
        .select_n_pin(select_n_pin), .lane_in_pin(lane_in_pin), .lanes(lanes),
        .rd_data(rd_data), .range_protected(range_protected), .rd_req(rd_req),
        .rd_addr(rd_addr), .sec_hit(sec_hit), .sec_index(sec_index),
        .write_latch_flag(write_latch_flag), .deep_power_down(deep_power_down),
        .wrap_setting_byte(wrap_setting_byte), .exec_pulse(exec_pulse),
        .exec_opcode(exec_opcode), .status_q_out(status_q_out), .config_out(config_out));
    sfc_host_model i_host (.clock(clock), .sclk_pin(sclk_pin), .select_n_pin(select_n_pin),
        .lane_in_pin(lane_in_pin), .lanes(lanes));
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic sbyte(input logic [7:0] b);
        logic [3:0] s;
        for (int i = 7; i >= 0; i--) i_host.tick({3'h0, b[i]}, 4'h1, s);
    endtask
    task automatic rbyte(input int w, output logic [7:0] b);
        logic [3:0] s;
        for (int i = 0; i < 8 / w; i++) begin
            i_host.tick(4'h0, 4'h0, s);
            case (w)
                1: b = {b[6:0], s[1]};
                2: b = {b[5:0], s[1:0]};
                default: b = {b[3:0], s};
            endcase
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] d);
        i_host.open_frame();
        sbyte(op);
        for (int i = 0; i < nb; i++) sbyte(d[23 - 8 * i -: 8]);
        i_host.close_frame();
    endtask
    // Opens a frame, reads one byte and closes the frame again
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int dum,
                      input int w, output logic [7:0] b);
        logic [3:0] s;
        i_host.open_frame();
        sbyte(op);
        if (aw == 4) for (int i = 5; i >= 0; i--) i_host.tick(a[4 * i +: 4], 4'hF, s);
        else if (aw == 2) for (int i = 11; i >= 0; i--) i_host.tick({2'h0, a[2 * i +: 2]}, 4'h3, s);
        else for (int i = 2; i >= 0; i--) sbyte(a[8 * i +: 8]);
        repeat (2) @(posedge clock);
        #1;
        if (op != SFC_OP_RDID) chk("rd_addr", rd_addr, a);
        chk("dummy_oe", lanes.oe, 4'h0);
        repeat (dum) i_host.tick(4'h0, 4'h0, s);
        rbyte(w, b);
        i_host.close_frame();
        chk("lane_oe", lanes.oe, 4'h0);
    endtask
    ////////////////////////////////////////
    task automatic t_latch();
        logic [3:0] s;
        int e = n_exec;
        cmd(SFC_OP_WRITE_ENABLE_CMD, 0, 0);
        chk("wel_set", write_latch_flag, 1);
        chk("exec_count", n_exec, e + 1);
        cmd(SFC_OP_WRDI, 0, 0);
        chk("wel_clr", write_latch_flag, 0);
        i_host.open_frame();
        sbyte(SFC_OP_WRITE_ENABLE_CMD);
        i_host.tick(4'h0, 4'h1, s);
        i_host.close_frame();
        chk("wel_nine_clocks", write_latch_flag, 0);
        cmd(SFC_OP_VWREN, 0, 0);
        chk("wel_volatile", write_latch_flag, 0);
        $display("TB: latch test done");
    endtask
    task automatic t_regs();
        cmd(SFC_OP_WRITE_ENABLE_CMD, 0, 0);
        cmd(SFC_OP_WRSR, 2, 24'h3C0000);
        chk("status_lo", status_q_out[5:2], 4'hF);
        cmd(SFC_OP_WRITE_ENABLE_CMD, 0, 0);
        cmd(SFC_OP_WRSR2, 1, 24'h020000);
        chk("status_hi", {status_q_out[9], status_q_out[5:2]}, 5'h1F);
        cmd(SFC_OP_WRITE_ENABLE_CMD, 0, 0);
        cmd(SFC_OP_WRCR, 1, 24'hA50000);
        chk("config", config_out, 8'hA5);
        t_stream(SFC_OP_RDSR1, 8'h3C, 2);
        t_stream(SFC_OP_RDSR2, 8'h02, 2);
        t_stream(SFC_OP_RDCR_A, 8'hA5, 2);
        t_stream(SFC_OP_RDCR_B, 8'hA5, 2);
        $display("TB: register test done");
    endtask
    task automatic t_stream(input logic [7:0] op, input logic [7:0] exp, input int rep);
        logic [7:0] b;
        i_host.open_frame();
        sbyte(op);
        for (int i = 0; i < rep; i++) begin
            rbyte(1, b);
            chk("stream_byte", b & (op == SFC_OP_RDSR1 ? 8'h3C : 8'hFF), exp);
        end
        i_host.close_frame();
    endtask
    task automatic t_reads();
        logic [7:0] ops [8] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7, 8'h5A};
        int aw [8] = '{1, 1, 1, 1, 2, 4, 4, 1};
        int dum [8] = '{0, 8, 8, 8, 4, 4, 2, 8};
        int w [8] = '{1, 1, 2, 4, 2, 4, 4, 1};
        logic [7:0] b;
        for (int k = 0; k < 8; k++) begin
            rd(ops[k], 24'h123456, aw[k], dum[k], w[k], b);
            chk("read_byte", b, 8'h96);
        end
        rd(SFC_OP_READ, 24'h000810, 1, 0, 1, b);
        chk("sec_sel", {sec_hit, sec_index}, 3'h6);
        $display("TB: read test done");
    endtask
    task automatic t_misc();
        logic [3:0] s;
        logic [7:0] b;
        int e;
        i_host.open_frame();
        sbyte(SFC_OP_WRAP);
        for (int i = 0; i < 8; i++) i_host.tick(i == 6 ? 4'h5 : 4'hA, 4'hF, s);
        i_host.close_frame();
        chk("wrap", wrap_setting_byte[6:4], 3'h5);
        cmd(SFC_OP_DPD, 0, 0);
        chk("dpd_on", deep_power_down, 1);
        rd(SFC_OP_RDID, 0, 1, 0, 1, b);
        chk("dev_id", {deep_power_down, b}, {1'b0, SFC_DEV_ID});
        cmd(SFC_OP_WRDI, 0, 0);
        e = n_exec;
        cmd(8'hFF, 1, 24'h060000);
        chk("unknown_op", {write_latch_flag, 16'(n_exec - e)}, 0);
        cmd(SFC_OP_WRITE_ENABLE_CMD, 0, 0);
        e = n_exec;
        i_host.open_frame();
        sbyte(SFC_OP_PP);
        repeat (3) sbyte(8'h01);
        repeat (4) i_host.tick(4'h1, 4'h1, s);
        i_host.close_frame();
        chk("pp_partial", {write_latch_flag, 16'(n_exec - e)}, 17'h10000);
        range_protected = 1'b1;
        cmd(SFC_OP_SE, 3, 24'h3F0000);
        chk("se_protected", write_latch_flag, 1);
        range_protected = 1'b0;
        cmd(SFC_OP_SE, 3, 24'h3F0000);
        chk("se_open", write_latch_flag, 0);
        $display("TB: misc test done");
    endtask
    ////////////////////////////////////////
    task automatic test_done();
        $display("TB: %0d checks, %0d failures", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        t_latch();
        t_regs();
        t_reads();
        t_misc();
        test_done();
    end
    // Roughly 64 us of traffic expected
    initial begin
        #500000;
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        test_done();
    end
endmodule // sfc_frontend_bench
bind sfc_frontend sfc_frontend_monitor i_mon (.clock(clock), .reset(reset), .sclk_pin(sclk_pin),
    .select_n_pin(select_n_pin), .lanes(lanes), .rd_req(rd_req), .rd_addr(rd_addr),
    .sec_hit(sec_hit), .sec_index(sec_index), .write_latch_flag(write_latch_flag),
    .exec_pulse(exec_pulse), .exec_opcode(exec_opcode));
